//--- hw/tech_defs.svh
// Constants of the surveillance command handler: codes, flag bits, offsets, timing.
// Assumes a 125 MHz core clock; included by bare name.
`ifndef TECH_DEFS_SVH
`define TECH_DEFS_SVH

`define TECH_CMD_FAST_READ 8'hb1
`define TECH_CMD_ON        8'ha2
`define TECH_CMD_OFF       8'ha3
`define TECH_CMD_FREEZE    8'ha4
`define TECH_CMD_ALARM     8'ha5
`define TECH_CMD_PROTECT   8'ha6
`define TECH_CMD_IDENT_WR  8'ha7

// Bit positions in the request flags byte
`define TECH_FLG_TWO_SUB   0
`define TECH_FLG_HIGH_RATE 1
`define TECH_FLG_INVENTORY 2
`define TECH_FLG_SELECT    4
`define TECH_FLG_ADDRESS   5
`define TECH_FLG_OPTION    6

`define TECH_RSP_FLAGS_OK  8'h00
`define TECH_RSP_FLAGS_ERR 8'h01
`define TECH_ERR_CODE      8'h0f
`define TECH_MASK_NONE     8'h00
`define TECH_MASK_BYTE     8'h08
`define TECH_MASK_WORD     8'h10

`define TECH_CRC_INIT      16'hffff
`define TECH_CRC_POLY      16'h8408

// Fixed alarm sequence, byte 0 in bits 7:0, each byte sent LSB first
`define TECH_SEQ 256'hef3772a512d19cf1b08baf6f869ada847649_82d23880b1e87f90a7d57062b32f

`define TECH_IDENT_RST     16'h0000

// APB register byte offsets and field positions
`define TECH_OFF_CTRL      8'h00
`define TECH_OFF_STATUS    8'h04
`define TECH_OFF_IDENT     8'h08
`define TECH_CTRL_PW_OK    0
`define TECH_ST_ON         0
`define TECH_ST_LOCK       1
`define TECH_ST_PROT_SURV  2
`define TECH_ST_PROT_AFI   3
`define TECH_ST_BUSY       4

// Reply turnaround after the reader's end of frame
`define TECH_CLK_MHZ       125
`define TECH_T1_NS         320900
`define TECH_T1_CYC        ((`TECH_T1_NS * `TECH_CLK_MHZ + 999) / 1000)

`endif

//--- hw/tech_pkg.sv
// Types of the surveillance command handler.
// Assumes nothing beyond a SystemVerilog compiler.
package tech_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_EOF, ST_TURN, ST_SEND} tech_state_e;
  typedef enum logic [1:0] {K_OK, K_ERR, K_IDENT, K_ALARM} tech_kind_e;
  typedef enum logic [1:0] {RATE_LOW, RATE_HIGH, RATE_FAST_LOW, RATE_FAST_HIGH} tech_rate_e;
  typedef enum logic [1:0] {PH_DATA, PH_CRC_LO, PH_CRC_HI} tech_phase_e;
endpackage

//--- hw/tech_tx_if.sv
// Byte stream from the command handler to the reply framer.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
`default_nettype none
interface tech_tx_if;
  logic       valid;
  logic       ready;
  logic       last;
  logic [7:0] data;
  modport src (output valid, output last, output data, input ready);
  modport snk (input valid, input last, input data, output ready);
endinterface
`default_nettype wire

//--- hw/tech_rsp_tx.sv
// Reply framer: passes flags and data bytes, then appends the CRC16 low byte first.
// Assumes the byte source holds valid, data and last until ready.
`timescale 1ns/1ps
`default_nettype none
`include "tech_defs.svh"
module tech_rsp_tx (
  input  wire logic       clk,
  input  wire logic       arst_n,
  tech_tx_if.snk          bus,
  input  wire logic       rsp_ready,
  output logic            rsp_valid,
  output logic [7:0]      rsp_data,
  output logic            rsp_last
);
  import tech_pkg::*;

  tech_phase_e ph_q;
  logic [15:0] crc_q;
  logic        free;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ `TECH_CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  assign free = !rsp_valid || rsp_ready;
  assign bus.ready = free && (ph_q == PH_DATA);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ph_q      <= PH_DATA;
      crc_q     <= `TECH_CRC_INIT;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      rsp_last  <= 1'b0;
    end else if (free) begin
      case (ph_q)
        PH_DATA: begin
          rsp_valid <= bus.valid;
          rsp_last  <= 1'b0;
          if (bus.valid) begin
            rsp_data <= bus.data;
            crc_q    <= crc_byte(crc_q, bus.data);
            if (bus.last) begin
              ph_q <= PH_CRC_LO;
            end
          end
        end
        PH_CRC_LO: begin
          rsp_valid <= 1'b1;
          rsp_data  <= ~crc_q[7:0];
          ph_q      <= PH_CRC_HI;
        end
        default: begin
          rsp_valid <= 1'b1;
          rsp_data  <= ~crc_q[15:8];
          rsp_last  <= 1'b1;
          crc_q     <= `TECH_CRC_INIT;
          ph_q      <= PH_DATA;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  tx_hold_a: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("reply byte changed while stalled");
  crc_tail_a: assert property (bus.valid && bus.ready && bus.last |=> ph_q == PH_CRC_LO)
    else $error("no CRC after last data byte");
endmodule
`default_nettype wire

//--- hw/tech_handler.sv
// Surveillance command handler: decodes checked request frames, keeps the
// surveillance state, builds replies and starts the fast page read.
// Assumes an upstream frame decoder (CRC, UID and maker code already checked)
// and an outside page read engine that serves the fast read.
//
// Notes on behaviour
// - Fast page read starts normal page read engine
// - Fast read replies at doubled data rate
// - Uplink rate and turnaround stay unchanged
// - Fast read reply only single subcarrier
// - Enable command sets state unless locked
// - Disable command clears state unless locked
// - Freeze command locks state and identifier
// - Protected commands need accepted password first
// - Option bit either value accepted
// - Write commands use write reply timing
// - Reply flags, optional error code, CRC16
// - Plain alarm answers sequence when enabled
// - Masked alarm answers only on identifier match
// - Zero mask length returns stored identifier
// - Alarm reply flags, 256-bit sequence, CRC
// - No alarm reply when disabled or bad
// - Protection command needs accepted password
// - Option selects surveillance or AFI protection
// - Protection can never be switched off
// - Protection command timed as option clear
// - Identifier write stores request identifier
// - Request is flags, code, maker, UID, CRC
// - Silent on any transmission error
// - Unsupported or failed gives 0Fh when addressed
`timescale 1ns/1ps
`default_nettype none
`include "tech_defs.svh"
module tech_handler #(
  parameter logic [15:0] TURN_CYC = 16'(`TECH_T1_CYC)
) (
  input  wire logic          CORE_CLK,
  input  wire logic          ARST_N,
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [7:0]    PADDR,
  input  wire logic [31:0]   PWDATA,
  output logic [31:0]        PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  input  wire logic          REQ_VALID,
  input  wire logic          REQ_ERR,
  input  wire logic [7:0]    REQ_FLAGS,
  input  wire logic [7:0]    REQ_CODE,
  input  wire logic [7:0]    REQ_MASK_LEN,
  input  wire logic [15:0]   REQ_IDENT,
  input  wire logic          REQ_EOF,
  output logic               FAST_GO,
  output tech_pkg::tech_rate_e RSP_RATE,
  output logic               RSP_VALID,
  output logic [7:0]         RSP_DATA,
  output logic               RSP_LAST,
  input  wire logic          RSP_READY,
  output logic               SURV_ON,
  output logic               AFI_PROTECTED,
  output logic               BUSY
);
  import tech_pkg::*;

  tech_tx_if tx_bus ();

  tech_state_e st_q;
  tech_kind_e  kind_q;
  tech_rate_e  rate_q;
  logic        surv_en_q;
  logic        lock_q;
  logic        prot_surv_q;
  logic        prot_afi_q;
  logic        pw_ok_q;
  logic [15:0] ident_q;
  logic [15:0] cnt_q;
  logic [5:0]  idx_q;
  logic        fast_q;
  logic [31:0] prdata_q;

  logic        accept;
  logic        opt;
  logic        addressed;
  logic        pw_need;
  logic        refused;
  logic        dec_reply;
  logic        dec_wait_eof;
  tech_kind_e  dec_kind;
  logic        dec_on;
  logic        dec_off;
  logic        dec_lock;
  logic        dec_prot_s;
  logic        dec_prot_a;
  logic        dec_ident;
  logic        dec_fast;
  logic [5:0]  last_idx;
  logic [8:0]  seq_pos;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states

  assign PREADY  = 1'b1;
  assign PRDATA  = prdata_q;
  assign PSLVERR = PSEL && PENABLE && (PADDR != `TECH_OFF_CTRL)
                   && (PADDR != `TECH_OFF_STATUS) && (PADDR != `TECH_OFF_IDENT);

  // Read data is captured in the setup cycle so the access cycle completes at once
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      prdata_q <= 32'h0000_0000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      if (PADDR == `TECH_OFF_CTRL) begin
        prdata_q <= {31'h0000_0000, pw_ok_q};
      end else if (PADDR == `TECH_OFF_STATUS) begin
        prdata_q <= {27'h000_0000, BUSY, prot_afi_q, prot_surv_q, lock_q, surv_en_q};
      end else if (PADDR == `TECH_OFF_IDENT) begin
        prdata_q <= {16'h0000, ident_q};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // Password acceptance is reported by the password firmware through this bit
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pw_ok_q <= 1'b0;
    end else if (PSEL && PENABLE && PWRITE && (PADDR == `TECH_OFF_CTRL)) begin
      pw_ok_q <= PWDATA[`TECH_CTRL_PW_OK];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request decode

  // Requests are dropped from acceptance until the last reply data byte enters the framer (CRC bytes may follow); the frame decoder sees BUSY
  assign accept    = REQ_VALID && !REQ_ERR && (st_q == ST_IDLE);
  assign opt       = REQ_FLAGS[`TECH_FLG_OPTION];
  assign addressed = (REQ_FLAGS[`TECH_FLG_ADDRESS] || REQ_FLAGS[`TECH_FLG_SELECT])
                     && !REQ_FLAGS[`TECH_FLG_INVENTORY];
  assign pw_need   = prot_surv_q && !pw_ok_q;

  always_comb begin
    dec_reply    = 1'b0;
    dec_wait_eof = 1'b0;
    dec_kind     = K_OK;
    dec_on       = 1'b0;
    dec_off      = 1'b0;
    dec_lock     = 1'b0;
    dec_prot_s   = 1'b0;
    dec_prot_a   = 1'b0;
    dec_ident    = 1'b0;
    dec_fast     = 1'b0;
    refused      = 1'b0;
    case (REQ_CODE)
      `TECH_CMD_ON, `TECH_CMD_OFF, `TECH_CMD_IDENT_WR: begin
        refused      = lock_q || pw_need;
        dec_on       = !refused && (REQ_CODE == `TECH_CMD_ON);
        dec_off      = !refused && (REQ_CODE == `TECH_CMD_OFF);
        dec_ident    = !refused && (REQ_CODE == `TECH_CMD_IDENT_WR);
        dec_reply    = !refused || addressed;
        dec_kind     = refused ? K_ERR : K_OK;
        dec_wait_eof = opt;
      end
      `TECH_CMD_FREEZE: begin
        refused      = pw_need;
        dec_lock     = !refused;
        dec_reply    = !refused || addressed;
        dec_kind     = refused ? K_ERR : K_OK;
        dec_wait_eof = opt;
      end
      `TECH_CMD_PROTECT: begin
        refused    = !pw_ok_q;
        dec_prot_s = !refused && !opt;
        dec_prot_a = !refused && opt;
        dec_reply  = !refused || addressed;
        dec_kind   = refused ? K_ERR : K_OK;
      end
      `TECH_CMD_ALARM: begin
        if (surv_en_q) begin
          if (!opt) begin
            dec_reply = 1'b1;
            dec_kind  = K_ALARM;
          end else if (REQ_MASK_LEN == `TECH_MASK_NONE) begin
            dec_reply = 1'b1;
            dec_kind  = K_IDENT;
          end else if (REQ_MASK_LEN == `TECH_MASK_BYTE) begin
            dec_reply = (REQ_IDENT[7:0] == ident_q[7:0]);
            dec_kind  = K_ALARM;
          end else if (REQ_MASK_LEN == `TECH_MASK_WORD) begin
            dec_reply = (REQ_IDENT == ident_q);
            dec_kind  = K_ALARM;
          end
        end
      end
      `TECH_CMD_FAST_READ: begin
        // Two-subcarrier request cannot be served and starts no page read; the inventory flag is not checked
        dec_fast = !REQ_FLAGS[`TECH_FLG_TWO_SUB];
      end
      default: begin
        dec_reply = addressed;
        dec_kind  = K_ERR;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Surveillance state

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      surv_en_q <= 1'b0;
    end else if (accept && dec_on) begin
      surv_en_q <= 1'b1;
    end else if (accept && dec_off) begin
      surv_en_q <= 1'b0;
    end
  end

  // Lock and both protections only ever set: no path back exists
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lock_q      <= 1'b0;
      prot_surv_q <= 1'b0;
      prot_afi_q  <= 1'b0;
    end else if (accept) begin
      lock_q      <= lock_q || dec_lock;
      prot_surv_q <= prot_surv_q || dec_prot_s;
      prot_afi_q  <= prot_afi_q || dec_prot_a;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ident_q <= `TECH_IDENT_RST;
    end else if (accept && dec_ident) begin
      ident_q <= REQ_IDENT;
    end
  end

  assign SURV_ON       = surv_en_q;
  assign AFI_PROTECTED = prot_afi_q;

  ////////////////////////////////////////////////////////////////////////////
  // Fast page read hand-off and reply rate

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fast_q <= 1'b0;
      rate_q <= RATE_LOW;
    end else begin
      fast_q <= accept && dec_fast;
      if (accept) begin
        if (dec_fast) begin
          rate_q <= REQ_FLAGS[`TECH_FLG_HIGH_RATE] ? RATE_FAST_HIGH : RATE_FAST_LOW;
        end else begin
          rate_q <= REQ_FLAGS[`TECH_FLG_HIGH_RATE] ? RATE_HIGH : RATE_LOW;
        end
      end
    end
  end

  // The page engine keeps the normal uplink and turnaround; only its downlink doubles
  assign FAST_GO  = fast_q;
  assign RSP_RATE = rate_q;

  ////////////////////////////////////////////////////////////////////////////
  // Reply sequencer

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q   <= ST_IDLE;
      kind_q <= K_OK;
      cnt_q  <= 16'h0000;
      idx_q  <= 6'h00;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (accept && dec_reply) begin
            kind_q <= dec_kind;
            cnt_q  <= TURN_CYC - 16'h0001;
            idx_q  <= 6'h00;
            st_q   <= dec_wait_eof ? ST_WAIT_EOF : ST_TURN;
          end
        end
        ST_WAIT_EOF: begin
          if (REQ_EOF) begin
            st_q <= ST_TURN;
          end
        end
        ST_TURN: begin
          if (cnt_q == 16'h0000) begin
            st_q <= ST_SEND;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        default: begin
          if (tx_bus.ready) begin
            if (idx_q == last_idx) begin
              st_q <= ST_IDLE;
            end else begin
              idx_q <= idx_q + 6'h01;
            end
          end
        end
      endcase
    end
  end

  always_comb begin
    case (kind_q)
      K_OK:    last_idx = 6'h00;
      K_ERR:   last_idx = 6'h01;
      K_IDENT: last_idx = 6'h02;
      default: last_idx = 6'h20;
    endcase
  end

  assign seq_pos = {6'(idx_q - 6'h01), 3'b000};

  always_comb begin
    tx_bus.data = `TECH_RSP_FLAGS_OK;
    if (idx_q != 6'h00) begin
      case (kind_q)
        K_ERR:   tx_bus.data = `TECH_ERR_CODE;
        K_IDENT: tx_bus.data = (idx_q == 6'h01) ? ident_q[7:0] : ident_q[15:8];
        default: tx_bus.data = 8'(`TECH_SEQ >> seq_pos);
      endcase
    end else if (kind_q == K_ERR) begin
      tx_bus.data = `TECH_RSP_FLAGS_ERR;
    end
  end

  assign tx_bus.valid = (st_q == ST_SEND);
  assign tx_bus.last  = (idx_q == last_idx);
  assign BUSY         = (st_q != ST_IDLE);

  tech_rsp_tx u_tx (
    .clk       (CORE_CLK),
    .arst_n    (ARST_N),
    .bus       (tx_bus.snk),
    .rsp_ready (RSP_READY),
    .rsp_valid (RSP_VALID),
    .rsp_data  (RSP_DATA),
    .rsp_last  (RSP_LAST)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  lock_freeze_a: assert property (lock_q |=> $stable(surv_en_q) && $stable(ident_q))
    else $error("locked surveillance state changed");
  lock_sticky_a: assert property (lock_q |=> lock_q)
    else $error("lock released");
  prot_sticky_a: assert property (prot_surv_q || prot_afi_q |=>
    (prot_surv_q || !$past(prot_surv_q)) && (prot_afi_q || !$past(prot_afi_q)))
    else $error("protection released");
  prot_pw_a: assert property ($rose(prot_surv_q) || $rose(prot_afi_q) |-> $past(pw_ok_q))
    else $error("protection set without password");
  enable_cmd_a: assert property (accept && REQ_CODE == `TECH_CMD_ON && !lock_q && !pw_need
    |=> surv_en_q)
    else $error("enable command ignored");
  disable_cmd_a: assert property (accept && REQ_CODE == `TECH_CMD_OFF && !lock_q && !pw_need
    |=> !surv_en_q)
    else $error("disable command ignored");
  pw_guard_a: assert property (pw_need && accept && REQ_CODE inside {`TECH_CMD_ON, `TECH_CMD_OFF}
    |=> $stable(surv_en_q))
    else $error("enable without password");
  ident_write_a: assert property (accept && REQ_CODE == `TECH_CMD_IDENT_WR && !lock_q
    && !pw_need |=> ident_q == $past(REQ_IDENT))
    else $error("identifier not stored");
  silent_err_a: assert property (st_q == ST_IDLE && REQ_VALID && REQ_ERR
    |=> st_q == ST_IDLE && !tx_bus.valid)
    else $error("reply to a damaged frame");
  alarm_off_a: assert property (accept && REQ_CODE == `TECH_CMD_ALARM && !surv_en_q
    |=> st_q == ST_IDLE)
    else $error("alarm reply while disabled");
  turn_hold_a: assert property ($rose(st_q == ST_TURN) |-> !tx_bus.valid [*2])
    else $error("reply before turnaround");
  fast_single_a: assert property (FAST_GO |-> RSP_RATE inside {RATE_FAST_LOW, RATE_FAST_HIGH}
    && !$past(REQ_FLAGS[`TECH_FLG_TWO_SUB]))
    else $error("fast read rate or subcarrier wrong");

  alarm_seq_c: cover property (tx_bus.valid && tx_bus.ready && kind_q == K_ALARM && tx_bus.last);
  ident_rsp_c: cover property (tx_bus.valid && kind_q == K_IDENT);
  refuse_c:    cover property (accept && refused && dec_reply);
  fast_go_c:   cover property (FAST_GO);
endmodule
`default_nettype wire

//--- testbench/tech_reader_model.sv
// Reader model: issues decoded request frames and collects reply bytes.
// Assumes the handler's request/reply ports and a single core clock.
`timescale 1ns/1ps
`default_nettype none
module tech_reader_model (
  input  wire logic        clk,
  input  wire logic        fast_go,
  input  wire logic        rsp_valid,
  input  wire logic [7:0]  rsp_data,
  output logic             rsp_ready,
  output logic             req_valid,
  output logic             req_err,
  output logic             req_eof,
  output logic [7:0]       req_flags,
  output logic [7:0]       req_code,
  output logic [7:0]       req_mask_len,
  output logic [15:0]      req_ident
);
  logic [7:0] rx[$];
  logic       slow     = 1'b0;
  logic [3:0] cyc      = 4'h0;
  int         fast_cnt = 0;
  initial begin
    rsp_ready = 1'b1;
    req_valid = 1'b0;
    req_err = 1'b0;
    req_eof = 1'b0;
    {req_flags, req_code, req_mask_len, req_ident} = '0;
  end
  // Slow mode stalls every other cycle to exercise reply hold
  always @(posedge clk) begin
    cyc <= cyc + 4'h1;
    rsp_ready <= !slow || cyc[0];
    if (rsp_valid && rsp_ready) rx.push_back(rsp_data);
    if (fast_go) fast_cnt++;
  end
  task send(input logic [7:0] f, input logic [7:0] c, input logic [7:0] m,
            input logic [15:0] id, input logic e, input logic bad);
    @(posedge clk);
    req_valid <= 1'b1;
    req_err <= bad;
    {req_flags, req_code, req_mask_len, req_ident} <= {f, c, m, id};
    @(posedge clk);
    req_valid <= 1'b0;
    req_err <= 1'b0;
    // Idle fields are inverted so a stale value cannot pass for a live one
    {req_flags, req_code, req_mask_len, req_ident} <= ~{f, c, m, id};
    if (e) begin
      repeat (3) @(posedge clk);
      req_eof <= 1'b1;
      @(posedge clk);
      req_eof <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

//--- testbench/tech_handler_tb_top.sv
// Bench for the surveillance handler: APB tasks and request/reply sequences.
// Assumes tech_reader_model as far side; turnaround shortened to 4 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "tech_defs.svh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tech_handler_tb_top;
  import tech_pkg::*;
  localparam logic [255:0] SEQ = `TECH_SEQ;
  logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, busy;
  logic req_valid, req_err, req_eof, fast_go, rsp_valid, rsp_last, rsp_ready;
  logic surv_on, afi_prot, er;
  logic [7:0] paddr, req_flags, req_code, req_mask_len, rsp_data;
  logic [15:0] req_ident;
  logic [31:0] pwdata, prdata, rd;
  tech_rate_e rsp_rate;
  logic [7:0] ex[$];
  int mismatches = 0;
  int samples_checked = 0;
  int fc;
  int lasts = 0;
  // Counts frame ends so every reply is seen to close exactly once
  always @(posedge core_clk) if (rsp_valid && rsp_ready && rsp_last) lasts++;
  always #4 core_clk = ~core_clk;
  tech_handler #(.TURN_CYC(16'd4)) tech_handler_inst (.CORE_CLK(core_clk), .ARST_N(arst_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .REQ_VALID(req_valid),
    .REQ_ERR(req_err), .REQ_FLAGS(req_flags), .REQ_CODE(req_code),
    .REQ_MASK_LEN(req_mask_len), .REQ_IDENT(req_ident), .REQ_EOF(req_eof),
    .FAST_GO(fast_go), .RSP_RATE(rsp_rate), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
    .RSP_LAST(rsp_last), .RSP_READY(rsp_ready), .SURV_ON(surv_on),
    .AFI_PROTECTED(afi_prot), .BUSY(busy));
  tech_reader_model tech_reader_model_inst (.clk(core_clk), .fast_go(fast_go),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ready(rsp_ready),
    .req_valid(req_valid), .req_err(req_err), .req_eof(req_eof), .req_flags(req_flags),
    .req_code(req_code), .req_mask_len(req_mask_len), .req_ident(req_ident));
  ////////////////////////////////////////////////////////////////////////////////
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c = 16'hffff;
    foreach (q[i]) for (int b = 0; b < 8; b++) c = (c[0] ^ q[i][b]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    return ~c;
  endfunction
  // Idle means no busy and no reply byte for several cycles in a row
  task xact(input logic [7:0] f, c, m, input logic [15:0] id, input logic e, bad);
    int idle;
    tech_reader_model_inst.rx.delete();
    tech_reader_model_inst.send(f, c, m, id, e, bad);
    idle = 0;
    for (int i = 0; i < 800 && idle < 6; i++) begin
      @(posedge core_clk);
      idle = (busy === 1'b0 && rsp_valid === 1'b0) ? idle + 1 : 0;
    end
    `CHK("idle", 6, idle)
  endtask
  task run(input string n, input logic [7:0] f, c, m, input logic [15:0] id, input logic e);
    logic [15:0] k;
    int l0;
    l0 = lasts;
    xact(f, c, m, id, e, 1'b0);
    k = crc16(ex);
    if (ex.size() > 0) ex = {ex, k[7:0], k[15:8]};
    `CHK(n, ex.size(), tech_reader_model_inst.rx.size())
    foreach (ex[i]) if (i < tech_reader_model_inst.rx.size())
      `CHK(n, ex[i], tech_reader_model_inst.rx[i])
    `CHK(n, (ex.size() > 0) ? 1 : 0, lasts - l0)
  endtask
  task alarm_ex();
    ex = {8'h00};
    for (int i = 0; i < 32; i++) ex.push_back(SEQ[8*i+:8]);
  endtask
  task report_and_stop();
    if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge core_clk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    {core_clk, arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    apb(0, `TECH_OFF_STATUS, 0); `CHK("status", 32'h0, rd)
    ex = {8'h00}; run("on", 8'h20, `TECH_CMD_ON, 0, 0, 0);
    `CHK("surv_on", 1'b1, surv_on)
    tech_reader_model_inst.slow = 1'b1;
    alarm_ex(); run("alarm", 8'h00, `TECH_CMD_ALARM, 0, 0, 0);
    tech_reader_model_inst.slow = 1'b0;
    ex = {8'h00}; run("id_wr", 8'h00, `TECH_CMD_IDENT_WR, 0, 16'h1234, 0);
    ex = {8'h00, 8'h34, 8'h12}; run("id_rd", 8'h40, `TECH_CMD_ALARM, 0, 0, 0);
    alarm_ex(); run("m8", 8'h40, `TECH_CMD_ALARM, 8'h08, 16'h0034, 0);
    alarm_ex(); run("m16", 8'h40, `TECH_CMD_ALARM, 8'h10, 16'h1234, 0);
    ex = {}; run("m16_miss", 8'h40, `TECH_CMD_ALARM, 8'h10, 16'h1235, 0);
    ex = {}; run("m_bad", 8'h40, `TECH_CMD_ALARM, 8'h18, 16'h1234, 0);
    ex = {8'h01, 8'h0f}; run("prot_nopw", 8'h20, `TECH_CMD_PROTECT, 0, 0, 0);
    apb(1, `TECH_OFF_CTRL, 32'h1);
    ex = {8'h00}; run("prot_s", 8'h20, `TECH_CMD_PROTECT, 0, 0, 0);
    ex = {8'h00}; run("prot_a", 8'h60, `TECH_CMD_PROTECT, 0, 0, 0);
    `CHK("afi_prot", 1'b1, afi_prot)
    apb(1, `TECH_OFF_CTRL, 32'h0);
    apb(0, `TECH_OFF_STATUS, 0); `CHK("status", 32'h0d, rd)
    ex = {8'h01, 8'h0f}; run("off_nopw", 8'h20, `TECH_CMD_OFF, 0, 0, 0);
    ex = {}; run("off_nonaddr", 8'h00, `TECH_CMD_OFF, 0, 0, 0);
    apb(1, `TECH_OFF_CTRL, 32'h1);
    ex = {8'h00}; run("off_opt", 8'h60, `TECH_CMD_OFF, 0, 0, 1);
    `CHK("surv_off", 1'b0, surv_on)
    ex = {}; run("alarm_off", 8'h00, `TECH_CMD_ALARM, 0, 0, 0);
    ex = {8'h00}; run("lock", 8'h20, `TECH_CMD_FREEZE, 0, 0, 0);
    ex = {8'h01, 8'h0f}; run("on_lock", 8'h20, `TECH_CMD_ON, 0, 0, 0);
    ex = {8'h01, 8'h0f}; run("id_lock", 8'h20, `TECH_CMD_IDENT_WR, 0, 16'h5555, 0);
    apb(0, `TECH_OFF_IDENT, 0); `CHK("ident", 32'h1234, rd)
    `CHK("surv_lock", 1'b0, surv_on)
    xact(8'h20, `TECH_CMD_ON, 0, 0, 0, 1);
    `CHK("crc_err", 0, tech_reader_model_inst.rx.size())
    ex = {}; run("unk_nonaddr", 8'h00, 8'hb0, 0, 0, 0);
    ex = {8'h01, 8'h0f}; run("unknown", 8'h20, 8'hc0, 0, 0, 0);
    fc = tech_reader_model_inst.fast_cnt;
    xact(8'h06, `TECH_CMD_FAST_READ, 0, 0, 0, 0); `CHK("rate", RATE_FAST_HIGH, rsp_rate)
    xact(8'h04, `TECH_CMD_FAST_READ, 0, 0, 0, 0); `CHK("rate", RATE_FAST_LOW, rsp_rate)
    xact(8'h07, `TECH_CMD_FAST_READ, 0, 0, 0, 0);
    `CHK("rate_two_sub", RATE_HIGH, rsp_rate)
    `CHK("fast_go", fc + 2, tech_reader_model_inst.fast_cnt)
    apb(0, 8'h0c, 0); `CHK("slverr", 1'b1, er)
    `CHK("unmapped", 32'h0, rd)
    report_and_stop();
  end
endmodule
`default_nettype wire
